// File: hw/op_state_pkg.sv
// constants and types for the operating-state and soft-reset controller
`default_nettype none
package op_state_pkg;
  // serial register port layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] ADDR_FUNC_ENABLE = 7'h46;
  localparam logic [6:0] ADDR_OP_STATE_CTL = 7'h47;
  localparam logic [6:0] ADDR_SOFT_RST = 7'h4F;
  localparam int FRAME_ADDR_BITS = 8;
  localparam int FRAME_BITS = 16;
  // field positions
  localparam int FAST_ALLOW_BIT = 2;
  localparam int STATUS_MSB = 7;
  localparam int STATUS_LSB = 5;
  localparam int CMD_MSB = 4;
  localparam int CMD_LSB = 0;
  // reset values
  localparam logic FAST_ALLOW_RESET = 1'b0;
  localparam logic [4:0] CMD_RESET = 5'h00;
  // readout codes
  localparam logic [2:0] CODE_PWRUP = 3'h0;
  localparam logic [2:0] CODE_SLEEP = 3'h1;
  localparam logic [2:0] CODE_STBY = 3'h2;
  localparam logic [2:0] CODE_TUNE = 3'h3;
  localparam logic [2:0] CODE_RX = 3'h4;
  localparam logic [2:0] CODE_EEPROM = 3'h5;
  // state-change command codes
  localparam logic [4:0] CMD_EEPROM = 5'h01;
  localparam logic [4:0] CMD_STBY = 5'h02;
  localparam logic [4:0] CMD_TUNE = 5'h04;
  localparam logic [4:0] CMD_RX = 5'h08;
  localparam logic [4:0] CMD_SLEEP = 5'h10;
  localparam logic [7:0] SOFT_RST_KEY = 8'hFF;
  // timing
  localparam longint CLK_HZ = 20000000;
  localparam longint SCLK_SLOW_HZ = 400000;
  localparam longint SCLK_FAST_HZ = 1000000;
  localparam int HALF_SLOW_CYC = int'(CLK_HZ / (2 * SCLK_SLOW_HZ));
  localparam int HALF_FAST_CYC = int'(CLK_HZ / (2 * SCLK_FAST_HZ));
  localparam int EDGE_JITTER_CYC = 2;
  localparam int GAP_W = 5;
  localparam longint PWRUP_TIME_US = 1000;
  localparam int PWRUP_CYCLES = int'((PWRUP_TIME_US * CLK_HZ) / 1000000);
  localparam longint TRANS_TIME_NS = 200;
  localparam int TRANS_CYCLES = int'((TRANS_TIME_NS * CLK_HZ + 999999999) / 1000000000);
  localparam longint SRST_HOST_WAIT_MS = 10;
  localparam int CNT_W = 24;
  // operating states, one-hot
  typedef enum logic [5:0] {
    ST_PWRUP = 6'h01,
    ST_SLEEP = 6'h02,
    ST_STBY = 6'h04,
    ST_TUNE = 6'h08,
    ST_RX = 6'h10,
    ST_EEPROM = 6'h20
  } op_state_type;
endpackage : op_state_pkg
`default_nettype wire

// File: hw/spi_frame_port.sv
// four-wire serial register port: synchronisers, frame shifter, read-back shifter
`timescale 1ns/1ps
`default_nettype none
module spi_frame_port (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // register side
  input wire logic abort_i,
  input wire logic [7:0] rd_data_i,
  output logic frame_start_o,
  output logic sclk_rise_o,
  output logic sclk_fall_o,
  output logic wr_stb_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  logic [1:0] sclk_s_reg;
  logic [1:0] csb_s_reg;
  logic [1:0] mosi_s_reg;
  logic sclk_d_reg;
  logic csb_d_reg;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] tx_reg, tx_next;
  logic [6:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic load_reg, load_next;
  logic dead_reg, dead_next;
  logic active;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, then one delay stage for edge detection
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s_reg <= 2'h0;
      csb_s_reg <= 2'h3;
      mosi_s_reg <= 2'h0;
      sclk_d_reg <= 1'b0;
      csb_d_reg <= 1'b1;
    end else if (ce_i) begin
      sclk_s_reg <= {sclk_s_reg[0], sclk_i};
      csb_s_reg <= {csb_s_reg[0], csb_n_i};
      mosi_s_reg <= {mosi_s_reg[0], mosi_i};
      sclk_d_reg <= sclk_s_reg[1];
      csb_d_reg <= csb_s_reg[1];
    end
  end

  assign active = ~csb_s_reg[1];
  assign sclk_rise_o = active & sclk_s_reg[1] & ~sclk_d_reg;
  assign sclk_fall_o = active & ~sclk_s_reg[1] & sclk_d_reg;
  assign frame_start_o = active & csb_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter: r/w bit, 7-bit address, 8 data bits, msb first
  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rd_next = rd_reg;
    wr_next = 1'b0;
    load_next = 1'b0;
    dead_next = dead_reg;
    if (load_reg) begin
      tx_next = rd_data_i;
    end
    if (!active) begin
      cnt_next = 5'h00;
      dead_next = 1'b0;
      rd_next = 1'b0;
    end else if (abort_i || dead_reg) begin
      dead_next = 1'b1; // frame dropped until select rises
    end else begin
      if (sclk_rise_o && (cnt_reg < 5'(op_state_pkg::FRAME_BITS))) begin
        sh_next = {sh_reg[6:0], mosi_s_reg[1]};
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == 5'(op_state_pkg::FRAME_ADDR_BITS - 1)) begin
          rd_next = sh_reg[6];
          addr_next = {sh_reg[5:0], mosi_s_reg[1]};
          load_next = sh_reg[6];
        end
        if (cnt_reg == 5'(op_state_pkg::FRAME_BITS - 1)) begin
          wdata_next = {sh_reg[6:0], mosi_s_reg[1]};
          wr_next = ~rd_reg;
        end
      end
      if (sclk_fall_o && (cnt_reg > 5'(op_state_pkg::FRAME_ADDR_BITS))) begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 5'h00;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= 7'h00;
      wdata_reg <= 8'h00;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      load_reg <= 1'b0;
      dead_reg <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      load_reg <= load_next;
      dead_reg <= dead_next;
    end
  end

  // outputs
  assign wr_stb_o = wr_reg & ce_i;
  assign addr_o = addr_reg;
  assign wdata_o = wdata_reg;
  assign miso_o = tx_reg[7];
  assign miso_oe_o = active & rd_reg & ~dead_reg;
endmodule : spi_frame_port
`default_nettype wire

// File: hw/op_state_and_soft_reset_ctrl.sv
// operating-state control, state readout, soft reset and serial clock speed permission
//
// Contract
// - sclk limit 400 kHz, or 1 MHz when allowed
// - three-bit state readout in bits 7:5
// - good power-up ends in sleep
// - failed power-up stays in power-up state
// - no command enters the power-up state
// - five command codes select new state
// - undefined command codes change nothing (the code still stores them in the command field, bits 4:0)
// - writing 0xFF to soft reset resets (the code drops the write in the power-up state, failed power-up included)
// - other soft reset values do nothing
// - soft reset equals power-on reset
`timescale 1ns/1ps
`default_nettype none
module op_state_and_soft_reset_ctrl #(
  parameter int PWRUP_CYCLES = op_state_pkg::PWRUP_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // serial register port
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // power-up result from analog
  input wire logic pwrup_fail_i,
  // state and status
  output logic [2:0] op_state_o,
  output logic soft_reset_o,
  output logic fast_serial_clock_allow_o,
  output logic power_up_failed_o,
  output logic sclk_overspeed_o
);
  localparam logic [4:0] GAP_MAX = 5'h1F;
  localparam logic [4:0] MIN_GAP_SLOW = 5'(op_state_pkg::HALF_SLOW_CYC - op_state_pkg::EDGE_JITTER_CYC);
  localparam logic [4:0] MIN_GAP_FAST = 5'(op_state_pkg::HALF_FAST_CYC - op_state_pkg::EDGE_JITTER_CYC);
  localparam logic [23:0] PWRUP_LAST = 24'(PWRUP_CYCLES - 1);
  localparam logic [23:0] TRANS_LAST = 24'(op_state_pkg::TRANS_CYCLES - 1);

  // state code of an operating state
  function automatic logic [2:0] state_code(input op_state_pkg::op_state_type s);
    unique case (s)
      op_state_pkg::ST_PWRUP: state_code = op_state_pkg::CODE_PWRUP;
      op_state_pkg::ST_SLEEP: state_code = op_state_pkg::CODE_SLEEP;
      op_state_pkg::ST_STBY: state_code = op_state_pkg::CODE_STBY;
      op_state_pkg::ST_TUNE: state_code = op_state_pkg::CODE_TUNE;
      op_state_pkg::ST_RX: state_code = op_state_pkg::CODE_RX;
      op_state_pkg::ST_EEPROM: state_code = op_state_pkg::CODE_EEPROM;
      default: state_code = op_state_pkg::CODE_PWRUP;
    endcase
  endfunction : state_code

  // command code valid
  function automatic logic cmd_valid(input logic [4:0] c);
    cmd_valid = (c == op_state_pkg::CMD_EEPROM) || (c == op_state_pkg::CMD_STBY) ||
                (c == op_state_pkg::CMD_TUNE) || (c == op_state_pkg::CMD_RX) || (c == op_state_pkg::CMD_SLEEP);
  endfunction : cmd_valid

  // target state of a command; never the power-up state
  function automatic op_state_pkg::op_state_type cmd_state(input logic [4:0] c);
    case (c)
      op_state_pkg::CMD_EEPROM: cmd_state = op_state_pkg::ST_EEPROM;
      op_state_pkg::CMD_STBY: cmd_state = op_state_pkg::ST_STBY;
      op_state_pkg::CMD_TUNE: cmd_state = op_state_pkg::ST_TUNE;
      op_state_pkg::CMD_RX: cmd_state = op_state_pkg::ST_RX;
      default: cmd_state = op_state_pkg::ST_SLEEP;
    endcase
  endfunction : cmd_state

  logic frame_start, sclk_rise, sclk_fall, wr_stb;
  logic [6:0] addr;
  logic [7:0] wdata, rd_data;
  logic [1:0] fail_s_reg;
  logic [4:0] gap_reg, gap_next;
  logic over_reg, over_next;
  logic too_fast, abort, reg_wr, cmd_acc, srst_hit;
  logic allow_reg, allow_next;
  logic [4:0] cmd_reg, cmd_next;
  op_state_pkg::op_state_type state_reg, state_next, target_reg, target_next;
  logic busy_reg, busy_next;
  logic failed_reg, failed_next;
  logic srst_reg;
  logic [23:0] cnt_reg, cnt_next;

  ////////////////////////////////////////////////////////////////////////////
  // serial port engine
  spi_frame_port u_port (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .csb_n_i(csb_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .abort_i(abort),
    .rd_data_i(rd_data),
    .frame_start_o(frame_start),
    .sclk_rise_o(sclk_rise),
    .sclk_fall_o(sclk_fall),
    .wr_stb_o(wr_stb),
    .addr_o(addr),
    .wdata_o(wdata)
  );

  // power-up fail level synchroniser
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fail_s_reg <= 2'h0;
    end else if (ce_i) begin
      fail_s_reg <= {fail_s_reg[0], pwrup_fail_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock half-period check against the allowed rate
  assign too_fast = (sclk_rise | sclk_fall) & ~frame_start &
                    (gap_reg < (allow_reg ? MIN_GAP_FAST : MIN_GAP_SLOW));
  // accesses dropped while powering up, which ends within the host's wait after reset
  assign abort = over_reg | too_fast | (state_reg == op_state_pkg::ST_PWRUP);
  assign reg_wr = wr_stb & ~abort;
  assign cmd_acc = reg_wr & (addr == op_state_pkg::ADDR_OP_STATE_CTL) &
                   cmd_valid(wdata[op_state_pkg::CMD_MSB:op_state_pkg::CMD_LSB]);
  assign srst_hit = reg_wr & (addr == op_state_pkg::ADDR_SOFT_RST) & (wdata == op_state_pkg::SOFT_RST_KEY);

  always_comb begin
    gap_next = gap_reg;
    over_next = over_reg;
    if (frame_start) begin
      gap_next = GAP_MAX;
      over_next = 1'b0;
    end else if (sclk_rise || sclk_fall) begin
      gap_next = 5'h00;
      over_next = over_reg | too_fast;
    end else if (gap_reg != GAP_MAX) begin
      gap_next = gap_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_reg <= 5'h1F;
      over_reg <= 1'b0;
    end else if (ce_i) begin
      gap_reg <= gap_next;
      over_reg <= over_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and state sequencer
  always_comb begin
    allow_next = allow_reg;
    cmd_next = cmd_reg;
    state_next = state_reg;
    target_next = target_reg;
    busy_next = busy_reg;
    failed_next = failed_reg;
    cnt_next = cnt_reg;
    if (srst_hit) begin
      // same effect as power-on reset
      allow_next = op_state_pkg::FAST_ALLOW_RESET;
      cmd_next = op_state_pkg::CMD_RESET;
      state_next = op_state_pkg::ST_PWRUP;
      target_next = op_state_pkg::ST_SLEEP;
      busy_next = 1'b0;
      failed_next = 1'b0;
      cnt_next = 24'h000000;
    end else if (state_reg == op_state_pkg::ST_PWRUP) begin
      if (!failed_reg) begin
        if (cnt_reg == PWRUP_LAST) begin
          failed_next = fail_s_reg[1];
          state_next = fail_s_reg[1] ? op_state_pkg::ST_PWRUP : op_state_pkg::ST_SLEEP;
          cnt_next = 24'h000000;
        end else begin
          cnt_next = cnt_reg + 24'h000001;
        end
      end
    end else begin
      if (reg_wr && (addr == op_state_pkg::ADDR_FUNC_ENABLE)) begin
        allow_next = wdata[op_state_pkg::FAST_ALLOW_BIT];
      end
      if (reg_wr && (addr == op_state_pkg::ADDR_OP_STATE_CTL)) begin
        cmd_next = wdata[op_state_pkg::CMD_MSB:op_state_pkg::CMD_LSB];
      end
      if (cmd_acc) begin
        target_next = cmd_state(wdata[op_state_pkg::CMD_MSB:op_state_pkg::CMD_LSB]);
        busy_next = 1'b1;
        cnt_next = 24'h000000;
      end else if (busy_reg) begin
        if (cnt_reg == TRANS_LAST) begin
          state_next = target_reg;
          busy_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 24'h000001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      allow_reg <= 1'b0;
      cmd_reg <= 5'h00;
      state_reg <= op_state_pkg::ST_PWRUP;
      target_reg <= op_state_pkg::ST_SLEEP;
      busy_reg <= 1'b0;
      failed_reg <= 1'b0;
      cnt_reg <= 24'h000000;
      srst_reg <= 1'b0;
    end else if (ce_i) begin
      allow_reg <= allow_next;
      cmd_reg <= cmd_next;
      state_reg <= state_next;
      target_reg <= target_next;
      busy_reg <= busy_next;
      failed_reg <= failed_next;
      cnt_reg <= cnt_next;
      srst_reg <= srst_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back mux; reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (addr)
      op_state_pkg::ADDR_FUNC_ENABLE: rd_data[op_state_pkg::FAST_ALLOW_BIT] = allow_reg;
      op_state_pkg::ADDR_OP_STATE_CTL: rd_data = {state_code(state_reg), cmd_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // outputs
  assign op_state_o = state_code(state_reg);
  assign soft_reset_o = srst_reg;
  assign fast_serial_clock_allow_o = allow_reg;
  assign power_up_failed_o = failed_reg;
  assign sclk_overspeed_o = over_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SPEED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && too_fast) |=> (sclk_overspeed_o && !wr_stb)) else $error("fast sclk edge not flagged");
  // readout only moves at the end of a transition, a soft reset or the power-up count
  AST_READOUT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $changed(op_state_o) |-> ($past(busy_reg) || $past(srst_hit) || $past(state_reg) == op_state_pkg::ST_PWRUP))
    else $error("readout changed outside a state change");
  AST_PWRUP_DONE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && state_reg == op_state_pkg::ST_PWRUP && !failed_reg && cnt_reg == PWRUP_LAST && !fail_s_reg[1])
    |=> (op_state_o == op_state_pkg::CODE_SLEEP)) else $error("power-up did not end in sleep");
  AST_PWRUP_FAIL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    power_up_failed_o |-> (op_state_o == op_state_pkg::CODE_PWRUP))
    else $error("failed power-up left the power-up state");
  AST_NO_PWRUP_ENTRY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg != op_state_pkg::ST_PWRUP && !srst_hit) |=> (state_reg != op_state_pkg::ST_PWRUP))
    else $error("power-up state entered by command");
  AST_CMD_DONE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cmd_acc && ce_i) ##1 (ce_i && !srst_hit && !cmd_acc)[*4] |=> (!busy_reg && op_state_o == state_code(target_reg)))
    else $error("state change not completed in time");
  AST_BAD_CMD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (reg_wr && addr == op_state_pkg::ADDR_OP_STATE_CTL && !cmd_valid(wdata[4:0]) && !busy_reg)
    |=> ($stable(state_reg) && !busy_reg)) else $error("bad command acted on");
  AST_SRST: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && srst_hit) |=> (soft_reset_o && op_state_o == op_state_pkg::CODE_PWRUP && !allow_reg && cnt_reg == 24'h000000))
    else $error("soft reset not applied");
  AST_NO_KEY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && wr_stb && addr == op_state_pkg::ADDR_SOFT_RST && wdata != op_state_pkg::SOFT_RST_KEY) |=> !soft_reset_o)
    else $error("soft reset without key");
  COV_SRST: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) srst_hit);
  COV_RX: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) op_state_o == op_state_pkg::CODE_RX);
  COV_OVER: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(sclk_overspeed_o));
  COV_FAIL: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(power_up_failed_o));
endmodule : op_state_and_soft_reset_ctrl
`default_nettype wire

// File: dv/spi_host_model.sv
// host model driving the four-wire serial register port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int WAIT_CYC = 40
) (
  // clock
  input wire logic clk_sys_i,
  // serial pins
  input wire logic miso_i,
  output logic sclk_o,
  output logic csb_n_o,
  output logic mosi_o
);
  // idle pins: deselected, clock still
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame: rw bit, 7 address bits, 8 data bits, msb first
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wdata, input int half,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {rw, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_sys_i);
    csb_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= frame[i];
      repeat (half) @(negedge clk_sys_i);
      if (i < 8) begin
        rdata[i] = miso_i; // sampled at the rising clock edge
      end
      sclk_o <= 1'b1;
      repeat (half) @(negedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (half) @(negedge clk_sys_i);
    csb_n_o <= 1'b1;
    mosi_o <= ~frame[0]; // released line shows no stale bit
    repeat (4) @(negedge clk_sys_i);
    // quiet period after the soft reset key
    if (rw == 1'b0 && addr == op_state_pkg::ADDR_SOFT_RST && wdata == op_state_pkg::SOFT_RST_KEY) begin
      repeat (WAIT_CYC) @(negedge clk_sys_i);
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the operating-state and soft-reset controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PWRUP_CYC = 16;
  localparam int SLOW = op_state_pkg::HALF_SLOW_CYC;
  localparam int FAST = op_state_pkg::HALF_FAST_CYC;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic pwrup_fail = 1'b0;
  logic miso_hold = 1'b0;
  logic [7:0] rd;
  wire logic sclk, csb_n, mosi, miso, miso_oe, miso_w;
  wire logic soft_reset, fast_allow, pwrup_failed, overspeed;
  wire logic [2:0] op_state;
  int srst_cnt = 0;
  int pwrup_cnt = 0;
  int error_cnt = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and released-line model
  always #25 clk_sys = ~clk_sys;
  assign miso_w = miso_oe ? miso : miso_hold;
  // monitors of pulses and power-up time
  always @(posedge clk_sys) begin
    if (miso_oe === 1'b1) miso_hold <= ~miso;
    if (soft_reset === 1'b1) srst_cnt <= srst_cnt + 1;
    if (op_state === op_state_pkg::CODE_PWRUP) pwrup_cnt <= pwrup_cnt + 1;
  end
  op_state_and_soft_reset_ctrl #(.PWRUP_CYCLES(PWRUP_CYC)) i_dut (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .ce_i(1'b1), .sclk_i(sclk), .csb_n_i(csb_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .pwrup_fail_i(pwrup_fail), .op_state_o(op_state),
    .soft_reset_o(soft_reset), .fast_serial_clock_allow_o(fast_allow), .power_up_failed_o(pwrup_failed),
    .sclk_overspeed_o(overspeed));
  spi_host_model #(.WAIT_CYC(PWRUP_CYC + 20)) i_host (
    .clk_sys_i(clk_sys), .miso_i(miso_w), .sclk_o(sclk), .csb_n_o(csb_n), .mosi_o(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_state(input logic [2:0] code);
    check({5'h00, op_state}, {5'h00, code});
  endtask : chk_state
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int half);
    i_host.xfer(1'b0, a, d, half, rd);
  endtask : wr
  task automatic rdr(input logic [6:0] a);
    i_host.xfer(1'b1, a, 8'h00, SLOW, rd);
  endtask : rdr
  task automatic wait_state(input logic [2:0] code);
    for (int n = 0; n < 60 && op_state !== code; n++) @(negedge clk_sys);
  endtask : wait_state
  task automatic do_reset();
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power_up();
    chk_state(op_state_pkg::CODE_PWRUP);
    wait_state(op_state_pkg::CODE_SLEEP);
    chk_state(op_state_pkg::CODE_SLEEP);
    check({7'h00, pwrup_failed}, 8'h00);
    rdr(op_state_pkg::ADDR_OP_STATE_CTL);
    check(rd, {op_state_pkg::CODE_SLEEP, op_state_pkg::CMD_RESET});
    rdr(op_state_pkg::ADDR_FUNC_ENABLE);
    check(rd, 8'h00);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_cmds();
    logic [4:0] cmd_tab [6] = '{5'h02, 5'h04, 5'h08, 5'h08, 5'h01, 5'h10};
    logic [2:0] code_tab [6] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h1};
    logic [4:0] bad_tab [4] = '{5'h00, 5'h03, 5'h11, 5'h1F};
    for (int i = 0; i < 6; i++) begin
      wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h7, cmd_tab[i]}, SLOW);
      wait_state(code_tab[i]);
      chk_state(code_tab[i]);
      rdr(op_state_pkg::ADDR_OP_STATE_CTL);
      check(rd, {code_tab[i], cmd_tab[i]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h0, bad_tab[i]}, SLOW);
      repeat (10) @(negedge clk_sys);
      chk_state(op_state_pkg::CODE_SLEEP);
    end
    $display("test commands done");
  endtask : t_cmds
  task automatic t_speed();
    wr(op_state_pkg::ADDR_FUNC_ENABLE, 8'hFF, SLOW); // reserved bits set on purpose
    check({7'h00, fast_allow}, 8'h01);
    rdr(op_state_pkg::ADDR_FUNC_ENABLE);
    check(rd, 8'h04);
    wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h0, op_state_pkg::CMD_STBY}, FAST);
    wait_state(op_state_pkg::CODE_STBY);
    chk_state(op_state_pkg::CODE_STBY);
    check({7'h00, overspeed}, 8'h00);
    wr(op_state_pkg::ADDR_FUNC_ENABLE, 8'h00, SLOW);
    wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h0, op_state_pkg::CMD_TUNE}, FAST);
    repeat (10) @(negedge clk_sys);
    chk_state(op_state_pkg::CODE_STBY);
    check({7'h00, overspeed}, 8'h01);
    $display("test speed done");
  endtask : t_speed
  task automatic t_soft();
    int n0;
    int p0;
    wr(op_state_pkg::ADDR_FUNC_ENABLE, 8'h04, SLOW);
    wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h0, op_state_pkg::CMD_TUNE}, SLOW);
    wait_state(op_state_pkg::CODE_TUNE);
    n0 = srst_cnt;
    wr(op_state_pkg::ADDR_SOFT_RST, 8'h00, SLOW);
    wr(op_state_pkg::ADDR_SOFT_RST, 8'hFE, SLOW);
    check(8'(srst_cnt - n0), 8'h00);
    chk_state(op_state_pkg::CODE_TUNE);
    p0 = pwrup_cnt;
    wr(op_state_pkg::ADDR_SOFT_RST, 8'hFF, SLOW);
    check(8'(srst_cnt - n0), 8'h01);
    check({7'h00, (pwrup_cnt - p0) >= PWRUP_CYC}, 8'h01);
    chk_state(op_state_pkg::CODE_SLEEP);
    check({7'h00, fast_allow}, 8'h00);
    rdr(op_state_pkg::ADDR_OP_STATE_CTL);
    check(rd, {op_state_pkg::CODE_SLEEP, 5'h00});
    $display("test soft_reset done");
  endtask : t_soft
  task automatic t_fail();
    pwrup_fail = 1'b1;
    do_reset();
    repeat (PWRUP_CYC + 10) @(negedge clk_sys);
    chk_state(op_state_pkg::CODE_PWRUP);
    check({7'h00, pwrup_failed}, 8'h01);
    wr(op_state_pkg::ADDR_OP_STATE_CTL, {3'h0, op_state_pkg::CMD_SLEEP}, SLOW);
    repeat (10) @(negedge clk_sys);
    chk_state(op_state_pkg::CODE_PWRUP);
    pwrup_fail = 1'b0;
    do_reset();
    wait_state(op_state_pkg::CODE_SLEEP);
    chk_state(op_state_pkg::CODE_SLEEP);
    $display("test power_up_fail done");
  endtask : t_fail
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    t_power_up();
    t_cmds();
    t_speed();
    t_soft();
    t_fail();
    conclude();
  end
  initial begin
    repeat (80000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
